// file: common/tpoh_map.vh
// Purpose: register indices, field positions, reset values and byte kinds
// Assumes: register byte address is four times the index
// Notes: included by the transmit path overhead insertion top level design file
`ifndef TPOH_MAP_VH
`define TPOH_MAP_VH

`define TPOH_ADDR_W 12
`define TPOH_IDX_W 10

// register indices
`define TPOH_IDX_G1_CTRL 10'h0b4
`define TPOH_IDX_STATUS 10'h0b5
`define TPOH_IDX_TRACE_FIRST 10'h0b6
`define TPOH_IDX_TRACE_LAST 10'h0f5
`define TPOH_IDX_CONFIG 10'h0f6
`define TPOH_IDX_ERR_GEN 10'h0f7
`define TPOH_IDX_LABEL 10'h0f8

// path overhead error generation fields
`define TPOH_ERRGEN_ALARM_BIT 0
`define TPOH_ERRGEN_CODE_LSB 4
`define TPOH_ERRGEN_CODE_MSB 6

// G1 control fields
`define TPOH_G1_AUTO_BIT 0
`define TPOH_G1_ENH_BIT 1
`define TPOH_G1_INH_BIT 2

// configuration fields
`define TPOH_CFG_TRACE_EN_BIT 0
`define TPOH_CFG_SONET_BIT 1
`define TPOH_CFG_GFP_BIT 2

// reset and fixed values
`define TPOH_LABEL_RESET 8'h18
`define TPOH_LABEL_LAPS 8'h18
`define TPOH_LABEL_GFP 8'h1b
`define TPOH_CFG_RESET 3'h2
`define TPOH_TRACE_TOP_SONET 6'h0f
`define TPOH_TRACE_TOP_SDH 6'h3f
`define TPOH_REI_MAX 4'h8
`define TPOH_ALL_ONES 8'hff

// remote defect codes, G1 bits 7 to 5
`define TPOH_RDI_NONE 3'h0
`define TPOH_RDI_ALARM 3'h4
`define TPOH_RDI_ENH_ALARM 3'h5
`define TPOH_RDI_ENH_UNEQ 3'h6
`define TPOH_RDI_ENH_PLM 3'h2
`define TPOH_RDI_ENH_NONE 3'h1

// byte kinds on the frame stream
`define TPOH_KIND_W 3
`define TPOH_KIND_TOH 3'h0
`define TPOH_KIND_PTR 3'h1
`define TPOH_KIND_SPE 3'h2
`define TPOH_KIND_J1 3'h3
`define TPOH_KIND_G1 3'h4
`define TPOH_KIND_C2 3'h5

`endif

// file: hdl/tpoh_fifo.v
// Purpose: small synchronous FIFO in the frame byte path
// Assumes: one clock, asynchronous active low reset
// Notes: count is exact, full and empty come from it
module tpoh_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  reg ready_reg;
  wire push;
  wire pop;

  // registered so the top's src_ready leaves a flip-flop
  assign in_ready = ready_reg;
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      ready_reg <= 1'b1;
    end else begin
      // pointers wrap naturally, depth is a power of two
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH[AW:0]);
    end
  end
endmodule

// file: hdl/tpoh_top.v
// Purpose: transmit path overhead insertion on the line-side frame byte stream
// Assumes: upstream tags each byte with its kind; APB slave with one wait state
// Notes: substitution happens at the FIFO output, so a register write
// Notes: affects bytes that leave after it, bytes already queued in the FIFO included
`include "tpoh_map.vh"

module tpoh_top #(
  parameter DATA_W = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TPOH_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire src_valid,
  output wire src_ready,
  input wire [DATA_W-1:0] src_data,
  input wire [`TPOH_KIND_W-1:0] src_kind,
  input wire src_frame_start,
  output reg line_valid,
  input wire line_ready,
  output reg [DATA_W-1:0] line_data,
  output reg line_frame_start,
  input wire rx_path_alarm,
  input wire rx_loss_of_pointer,
  input wire rx_unequipped,
  input wire rx_label_mismatch,
  input wire [3:0] rx_b3_errors
);
  localparam FW = DATA_W + `TPOH_KIND_W + 1;
  localparam [2:0] CFG_RST = `TPOH_CFG_RESET;

  reg [7:0] trace_reg [0:63];
  reg [7:0] label_reg;
  reg [2:0] manual_defect_code_reg;
  reg force_path_alarm_reg;
  reg auto_remote_defect_reg;
  reg enhanced_remote_defect_reg;
  reg path_error_report_inhibit_reg;
  reg trace_enable_reg;
  reg sonet_select_reg;
  reg gfp_mode_reg;
  reg [5:0] trace_idx_reg;
  reg [5:0] trace_idx_next;
  reg [2:0] rdi_code;
  reg [3:0] rei_value;
  reg [7:0] out_byte;
  reg [31:0] read_value;
  reg mapped;
  integer i;

  wire [`TPOH_IDX_W-1:0] reg_idx;
  wire aligned;
  wire is_trace;
  wire [5:0] trace_slot;
  wire [`TPOH_IDX_W-1:0] trace_off;
  wire bus_take;
  wire bus_write;
  wire wr_byte;
  wire [FW-1:0] fifo_out;
  wire fifo_out_valid;
  wire fifo_pop;
  wire [FIFO_AW:0] fifo_level;
  wire [DATA_W-1:0] q_data;
  wire [`TPOH_KIND_W-1:0] q_kind;
  wire q_frame_start;
  wire [5:0] trace_top;
  wire [5:0] trace_eff;
  wire [7:0] g1_byte;

  assign reg_idx = paddr[`TPOH_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign is_trace = (reg_idx >= `TPOH_IDX_TRACE_FIRST) && (reg_idx <= `TPOH_IDX_TRACE_LAST);
  assign trace_off = reg_idx - `TPOH_IDX_TRACE_FIRST;
  assign trace_slot = trace_off[5:0];
  // the write lands on the edge where pready is seen high
  assign bus_take = psel && penable && pready;
  assign bus_write = bus_take && pwrite && mapped;
  assign wr_byte = bus_write && pstrb[0];

  // address decode and read mux
  always @* begin
    read_value = 32'h0000_0000;
    mapped = aligned;
    if (is_trace) begin
      read_value[7:0] = trace_reg[trace_slot];
    end else begin
      case (reg_idx)
        `TPOH_IDX_G1_CTRL: begin
          read_value[`TPOH_G1_AUTO_BIT] = auto_remote_defect_reg;
          read_value[`TPOH_G1_ENH_BIT] = enhanced_remote_defect_reg;
          read_value[`TPOH_G1_INH_BIT] = path_error_report_inhibit_reg;
        end
        `TPOH_IDX_STATUS: begin
          read_value[5:0] = trace_idx_reg;
          read_value[8+FIFO_AW:8] = fifo_level;
          read_value[16] = force_path_alarm_reg;
          read_value[19:17] = rdi_code;
          read_value[23:20] = rei_value;
        end
        `TPOH_IDX_CONFIG: begin
          read_value[`TPOH_CFG_TRACE_EN_BIT] = trace_enable_reg;
          read_value[`TPOH_CFG_SONET_BIT] = sonet_select_reg;
          read_value[`TPOH_CFG_GFP_BIT] = gfp_mode_reg;
        end
        `TPOH_IDX_ERR_GEN: begin
          read_value[`TPOH_ERRGEN_CODE_MSB:`TPOH_ERRGEN_CODE_LSB] = manual_defect_code_reg;
          read_value[`TPOH_ERRGEN_ALARM_BIT] = force_path_alarm_reg;
        end
        `TPOH_IDX_LABEL: begin
          read_value[7:0] = label_reg;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
    if (!aligned) begin
      read_value = 32'h0000_0000;
    end
  end

  // APB handshake: one wait state in every access phase
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      // prdata keeps the last read answer across writes
      if (!pwrite) begin
        prdata <= read_value;
      end
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software registers; status index is read only
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 64; i = i + 1) begin
        trace_reg[i] <= 8'h00;
      end
      label_reg <= `TPOH_LABEL_RESET;
      manual_defect_code_reg <= 3'h0;
      force_path_alarm_reg <= 1'b0;
      auto_remote_defect_reg <= 1'b0;
      enhanced_remote_defect_reg <= 1'b0;
      path_error_report_inhibit_reg <= 1'b0;
      trace_enable_reg <= CFG_RST[`TPOH_CFG_TRACE_EN_BIT];
      sonet_select_reg <= CFG_RST[`TPOH_CFG_SONET_BIT];
      gfp_mode_reg <= CFG_RST[`TPOH_CFG_GFP_BIT];
    end else if (wr_byte) begin
      if (is_trace) begin
        trace_reg[trace_slot] <= pwdata[7:0];
      end else begin
        case (reg_idx)
          `TPOH_IDX_G1_CTRL: begin
            auto_remote_defect_reg <= pwdata[`TPOH_G1_AUTO_BIT];
            enhanced_remote_defect_reg <= pwdata[`TPOH_G1_ENH_BIT];
            path_error_report_inhibit_reg <= pwdata[`TPOH_G1_INH_BIT];
          end
          `TPOH_IDX_CONFIG: begin
            trace_enable_reg <= pwdata[`TPOH_CFG_TRACE_EN_BIT];
            sonet_select_reg <= pwdata[`TPOH_CFG_SONET_BIT];
            gfp_mode_reg <= pwdata[`TPOH_CFG_GFP_BIT];
            // GFP mode change reloads the label; software may still override it
            if (pwdata[`TPOH_CFG_GFP_BIT] != gfp_mode_reg) begin
              label_reg <= pwdata[`TPOH_CFG_GFP_BIT] ? `TPOH_LABEL_GFP : `TPOH_LABEL_LAPS;
            end
          end
          `TPOH_IDX_ERR_GEN: begin
            manual_defect_code_reg <= pwdata[`TPOH_ERRGEN_CODE_MSB:`TPOH_ERRGEN_CODE_LSB];
            force_path_alarm_reg <= pwdata[`TPOH_ERRGEN_ALARM_BIT];
          end
          `TPOH_IDX_LABEL: begin
            label_reg <= pwdata[7:0];
          end
          default: begin
            label_reg <= label_reg;
          end
        endcase
      end
    end
  end

  tpoh_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data({src_frame_start, src_kind, src_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign q_data = fifo_out[DATA_W-1:0];
  assign q_kind = fifo_out[DATA_W+`TPOH_KIND_W-1:DATA_W];
  assign q_frame_start = fifo_out[FW-1];
  // output stage stalls the FIFO when the line side holds off
  assign fifo_pop = fifo_out_valid && (!line_valid || line_ready);

  assign trace_top = sonet_select_reg ? `TPOH_TRACE_TOP_SONET : `TPOH_TRACE_TOP_SDH;
  // an index left above the top by a mode change restarts at the top
  assign trace_eff = (trace_idx_reg > trace_top) ? trace_top : trace_idx_reg;

  always @* begin
    if (!trace_enable_reg) begin
      trace_idx_next = trace_top;
    end else if (fifo_pop && q_kind == `TPOH_KIND_J1) begin
      trace_idx_next = (trace_eff == 6'h00) ? trace_top : trace_eff - 6'h01;
    end else begin
      trace_idx_next = trace_idx_reg;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trace_idx_reg <= `TPOH_TRACE_TOP_SDH;
    end else begin
      trace_idx_reg <= trace_idx_next;
    end
  end

  // remote defect code for G1 bits 7 to 5
  always @* begin
    if (!auto_remote_defect_reg) begin
      rdi_code = manual_defect_code_reg;
    end else if (!enhanced_remote_defect_reg) begin
      rdi_code = (rx_path_alarm || rx_loss_of_pointer) ? `TPOH_RDI_ALARM : `TPOH_RDI_NONE;
    end else if (rx_path_alarm || rx_loss_of_pointer) begin
      rdi_code = `TPOH_RDI_ENH_ALARM;
    end else if (rx_unequipped) begin
      rdi_code = `TPOH_RDI_ENH_UNEQ;
    end else if (rx_label_mismatch) begin
      rdi_code = `TPOH_RDI_ENH_PLM;
    end else begin
      rdi_code = `TPOH_RDI_ENH_NONE;
    end
  end

  // more than eight errors cannot occur per frame; clamp guards a bad count
  always @* begin
    if (path_error_report_inhibit_reg) begin
      rei_value = 4'h0;
    end else if (rx_b3_errors > `TPOH_REI_MAX) begin
      rei_value = `TPOH_REI_MAX;
    end else begin
      rei_value = rx_b3_errors;
    end
  end

  assign g1_byte = {rdi_code, 1'b0, rei_value};

  // byte substitution; alarm covers pointer and whole envelope, POH included
  always @* begin
    out_byte = q_data;
    if (force_path_alarm_reg && q_kind != `TPOH_KIND_TOH) begin
      out_byte = `TPOH_ALL_ONES;
    end else begin
      case (q_kind)
        `TPOH_KIND_J1: begin
          if (trace_enable_reg) begin
            out_byte = trace_reg[trace_eff];
          end
        end
        `TPOH_KIND_G1: begin
          out_byte = g1_byte;
        end
        `TPOH_KIND_C2: begin
          out_byte = label_reg;
        end
        default: begin
          out_byte = q_data;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_valid <= 1'b0;
      line_data <= {DATA_W{1'b0}};
      line_frame_start <= 1'b0;
    end else if (!line_valid || line_ready) begin
      line_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        line_data <= out_byte;
        line_frame_start <= q_frame_start;
      end
    end
  end
endmodule

// file: tb/tpoh_line_sink.sv
// Purpose: line-side sink for the frame stream
// Assumes: ready changes just after a clock edge
// Notes: stall holds ready low so the FIFO can fill
module tpoh_line_sink (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic stall,
  output logic line_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_ready <= 1'b0;
    end else begin
      line_ready <= !stall && ($urandom % 4 != 0);
    end
  end
endmodule

// file: tb/tpoh_top_assertions.sv
// Purpose: port checks for tpoh_top
// Assumes: one clock, async active low reset
// Notes: byte contents are judged by the bench
module tpoh_top_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic line_valid,
  input wire logic line_ready,
  input wire logic [7:0] line_data,
  input wire logic line_frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // fixed wait state, so a late answer is a fault
  apb_wait_a: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not in second access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read gave data");
  rdata_hold_a: assert property (!(pready && !pwrite) |-> $stable(prdata))
    else $error("prdata moved without a read");
  valid_hold_a: assert property (line_valid && !line_ready |=> line_valid)
    else $error("line byte dropped under stall");
  data_hold_a: assert property (line_valid && !line_ready |=>
    $stable(line_data) && $stable(line_frame_start))
    else $error("line byte changed under stall");
endmodule

bind tpoh_top tpoh_top_assertions chk (.core_clk, .reset_n, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .line_valid, .line_ready, .line_data, .line_frame_start);

// file: tb/tpoh_top_tb_top.sv
// Purpose: self-checking bench for tpoh_top
// Assumes: registers change only while no byte is in flight
// Notes: substitution is at pop time, hence the drains
module tpoh_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic src_valid = 0, src_frame_start = 0, alarm = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hf, rxd = 0, rx_b3_errors = 0;
  logic [7:0] src_data = 0, label = 8'h18, byt;
  logic [2:0] src_kind = 0, cfg = 3'h2, g1c = 0, code = 0;
  wire rx_path_alarm = rxd[0];
  wire rx_unequipped = rxd[1];
  wire rx_label_mismatch = rxd[2];
  wire rx_loss_of_pointer = rxd[3];
  wire [31:0] prdata;
  wire pready, pslverr, src_ready, line_valid, line_ready, line_frame_start;
  wire [7:0] line_data;
  logic [32:0] rq[$];
  logic [8:0] lq[$];
  logic [7:0] trace[64];
  int n_fail = 0, n_tests = 0, tidx, top, i;
  tpoh_top uut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .src_valid, .src_ready, .src_data, .src_kind,
    .src_frame_start, .line_valid, .line_ready, .line_data, .line_frame_start,
    .rx_path_alarm, .rx_loss_of_pointer, .rx_unequipped, .rx_label_mismatch, .rx_b3_errors);
  tpoh_line_sink sink (.core_clk, .reset_n, .stall, .line_ready);
  always #5 core_clk = ~core_clk;
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    results();
  endtask
  task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t register got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t line byte got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) chk_reg({pslverr, prdata}, rq.pop_front());
    if (line_valid && line_ready) chk_byte({line_frame_start, line_data}, lq.pop_front());
  end
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!w) rq.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [32:0] e);
    apb(1'b0, idx, 8'h0, e);
  endtask
  task automatic put(input logic [2:0] k, input logic [7:0] d, input logic fs,
                     input logic [7:0] e);
    int n;
    src_valid <= 1'b1;
    src_kind <= k;
    src_data <= d;
    src_frame_start <= fs;
    lq.push_back({fs, e});
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (src_ready !== 1'b1 && n < 200);
    if (src_ready !== 1'b1) hang();
  endtask
  task automatic drain();
    int n;
    src_valid <= 1'b0;
    n = 0;
    while (lq.size() != 0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (lq.size() != 0) hang();
  endtask
  function automatic logic [7:0] g1_exp();
    logic [2:0] c;
    logic p;
    p = rxd[0] | rxd[3];
    if (!g1c[0]) c = code;
    else if (!g1c[1]) c = p ? 3'h4 : 3'h0;
    else c = p ? 3'h5 : rxd[1] ? 3'h6 : rxd[2] ? 3'h2 : 3'h1;
    return {c, 1'b0, g1c[2] ? 4'h0 : (rx_b3_errors > 4'h8 ? 4'h8 : rx_b3_errors)};
  endfunction
  // one frame: overhead, pointer, J1, G1, C2, payload
  task automatic frame();
    logic [7:0] d;
    d = 8'($urandom);
    put(3'h0, d, 1'b1, d);
    put(3'h1, ~d, 1'b0, alarm ? 8'hff : ~d);
    put(3'h3, d, 1'b0, alarm ? 8'hff : cfg[0] ? trace[tidx] : d);
    if (cfg[0]) tidx = (tidx == 0) ? top : tidx - 1;
    put(3'h4, d, 1'b0, alarm ? 8'hff : g1_exp());
    put(3'h5, d, 1'b0, alarm ? 8'hff : label);
    put(3'h2, d ^ 8'h5a, 1'b0, alarm ? 8'hff : d ^ 8'h5a);
  endtask
  initial begin
    void'($urandom(32'h9ee5_073c));
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(10'h0f8, 33'h18);
    rd(10'h0f7, 33'h0);
    rd(10'h0ff, 33'h1_0000_0000);
    for (i = 0; i < 64; i++) begin
      rd(10'(i + 'h0b6), 33'h0);
      trace[i] = 8'($urandom);
      wr(10'(i + 'h0b6), trace[i]);
      rd(10'(i + 'h0b6), {25'h0, trace[i]});
    end
    cfg = 3'h3;
    wr(10'h0f6, 8'h03);
    top = 15;
    tidx = 15;
    repeat (20) frame();
    drain();
    cfg = 3'h1;
    wr(10'h0f6, 8'h00);
    wr(10'h0f6, 8'h01);
    top = 63;
    tidx = 63;
    repeat (66) frame();
    drain();
    for (i = 0; i < 40; i++) begin
      g1c = 3'($urandom);
      code = 3'($urandom);
      rxd <= 4'($urandom);
      rx_b3_errors <= 4'($urandom);
      wr(10'h0b4, {5'h0, g1c});
      wr(10'h0f7, {1'b0, code, 4'h0});
      frame();
      drain();
    end
    pstrb <= 4'h0;
    wr(10'h0f8, 8'h55);
    pstrb <= 4'hf;
    rd(10'h0f8, 33'h18);
    cfg = 3'h4;
    wr(10'h0f6, 8'h04);
    label = 8'h1b;
    rd(10'h0f8, 33'h1b);
    wr(10'h0f6, 8'h00);
    label = 8'h18;
    rd(10'h0f8, 33'h18);
    label = 8'($urandom);
    wr(10'h0f8, label);
    alarm = 1'b1;
    wr(10'h0f7, 8'h01);
    frame();
    drain();
    alarm = 1'b0;
    wr(10'h0f7, 8'h00);
    frame();
    drain();
    // stalled line side: 16 in the FIFO plus one in the output register
    stall <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 17; i++) begin
      byt = 8'($urandom);
      put(3'h2, byt, 1'b0, byt);
    end
    src_valid <= 1'b0;
    @(posedge core_clk);
    chk_reg({32'h0, src_ready}, 33'h0);
    byt = g1_exp();
    rd(10'h0b5, {1'b0, 8'h00, byt[3:0], byt[7:5], 1'b0, 3'h0, 5'h10, 2'b00, 6'h3f});
    stall <= 1'b0;
    drain();
    results();
  end
endmodule
